// >>> tid_regs.svh
// Function
// - recognize all 55 instructions and sort them into their eight groups
// - stack store is a word transfer to memory through the stack pointer, predecrement
// - stack load is a word transfer from memory through the stack pointer, postincrement
// - stack store and load share the word transfer decode path
// - transfer moves byte or word: register, memory, or immediate data
// - word transfers accept direct, indirect, disp16, abs16, imm16 (loads only), predecrement, postincrement
// - short absolute mode is legal for byte transfers only
// - stack load moves a full 16-bit register value from the stack
// - stack store writes a full 16-bit register value onto the stack
// - predecrement lowers the address register by 1 or 2 first and keeps it
// - postincrement raises the address register by 1 or 2 after the access
// - short absolute address has its upper eight bits forced to ones
// - word transfer to an odd address clears address bit zero
`ifndef TID_REGS_SVH
`define TID_REGS_SVH
`define TID_NUM_INSTR 6'h37
`define TID_LAST_XFER 6'h00
`define TID_LAST_ARITH 6'h0E
`define TID_LAST_LOGIC 6'h12
`define TID_LAST_SHIFT 6'h1A
`define TID_LAST_BIT 6'h28
`define TID_LAST_BRANCH 6'h2D
`define TID_LAST_SYSCTL 6'h35
`define TID_SHORT_ABS_HI 8'hFF
`define TID_STACK_REG 3'h7
`define TID_STEP_BYTE 16'h0001
`define TID_STEP_WORD 16'h0002
`endif

// >>> tid_pkg.sv
package tid_pkg;
    typedef enum logic [2:0] {
        TID_GRP_TRANSFER, TID_GRP_ARITH, TID_GRP_LOGIC, TID_GRP_SHIFT,
        TID_GRP_BIT, TID_GRP_BRANCH, TID_GRP_SYSCTL, TID_GRP_BLOCK
    } tid_group_type;
    typedef enum logic [2:0] {
        TID_MODE_DIRECT, TID_MODE_INDIRECT, TID_MODE_DISP16, TID_MODE_ABS16,
        TID_MODE_ABS8, TID_MODE_IMM, TID_MODE_PREDEC, TID_MODE_POSTINC
    } tid_mode_type;
    typedef enum logic [0:0] {
        TID_ST_IDLE, TID_ST_MEM
    } tid_state_type;
endpackage

// >>> tid_transfer_decode.sv
`timescale 1ns/1ps
`include "tid_regs.svh"
module tid_transfer_decode (
    input wire logic clock,                          // 20 MHz cpu clock
    input wire logic rst,                            // synchronous reset, active high
    input wire logic instr_valid,                    // instruction offered this cycle
    input wire logic [5:0] instr_code,               // instruction number 0..54
    input wire logic xfer_store,                     // 1: register to memory
    input wire logic xfer_word,                      // 1: word size, 0: byte size
    input wire tid_pkg::tid_mode_type xfer_mode,     // addressing mode
    input wire logic [2:0] xfer_reg,                 // data register field
    input wire logic [2:0] addr_reg,                 // address or source register field
    input wire logic [15:0] ext_word,                // displacement, address or immediate
    input wire logic mem_ack,                        // data memory access complete
    input wire logic [15:0] mem_rdata,               // data memory read data
    input wire logic [2:0] peek_sel,                 // general register to observe
    output logic instr_ready,                        // idle, instruction may be offered
    output tid_pkg::tid_group_type group_out,        // group of last in-range code taken
    output logic illegal,                            // pulse: rejected instruction
    output logic done,                               // pulse: transfer finished
    output logic [15:0] mem_addr,                    // data memory address
    output logic [15:0] mem_wdata,                   // data memory write data
    output logic mem_rd,                             // read request, held until ack
    output logic mem_wr,                             // write request, held until ack
    output logic mem_word,                           // 1: word access
    output logic [15:0] peek_data                    // selected general register
);
    import tid_pkg::*;

    function automatic tid_group_type group_of(input logic [5:0] code);
        if (code <= `TID_LAST_XFER) return TID_GRP_TRANSFER;
        else if (code <= `TID_LAST_ARITH) return TID_GRP_ARITH;
        else if (code <= `TID_LAST_LOGIC) return TID_GRP_LOGIC;
        else if (code <= `TID_LAST_SHIFT) return TID_GRP_SHIFT;
        else if (code <= `TID_LAST_BIT) return TID_GRP_BIT;
        else if (code <= `TID_LAST_BRANCH) return TID_GRP_BRANCH;
        else if (code <= `TID_LAST_SYSCTL) return TID_GRP_SYSCTL;
        else return TID_GRP_BLOCK;
    endfunction

    function automatic logic [15:0] calc_ea(input tid_mode_type mode, input logic [15:0] base,
                                            input logic [15:0] ext, input logic [15:0] step,
                                            input logic word);
        logic [15:0] ea;
        ea = base;
        unique case (mode)
            TID_MODE_DISP16: ea = base + ext;
            TID_MODE_ABS16: ea = ext;
            TID_MODE_ABS8: ea = {`TID_SHORT_ABS_HI, ext[7:0]};
            TID_MODE_PREDEC: ea = base - step;
            default: ea = base;
        endcase
        if (word) ea[0] = 1'b0;
        return ea;
    endfunction

    tid_state_type state_ff, nxt_state;
    logic [15:0] reg_ff [8];
    logic op_store_ff, op_word_ff;
    logic [2:0] op_reg_ff, op_areg_ff;
    tid_mode_type op_mode_ff;
    logic [15:0] op_step_ff;

    wire code_ok = instr_code < `TID_NUM_INSTR;
    wire tid_group_type dec_group = group_of(instr_code);
    // one decode path for stack aliases
    wire is_xfer = code_ok && (dec_group == TID_GRP_TRANSFER);
    wire bad_abs8 = xfer_word && (xfer_mode == TID_MODE_ABS8);
    wire bad_imm = xfer_store && (xfer_mode == TID_MODE_IMM);
    wire take = instr_valid && (state_ff == TID_ST_IDLE);
    wire run = take && is_xfer && !bad_abs8 && !bad_imm;
    wire reject = take && !(run || (code_ok && !is_xfer));
    wire reg_only = (xfer_mode == TID_MODE_DIRECT) || (xfer_mode == TID_MODE_IMM);
    wire [15:0] step = xfer_word ? `TID_STEP_WORD : `TID_STEP_BYTE;
    wire [15:0] base = reg_ff[addr_reg];
    wire [15:0] src_val = reg_ff[xfer_reg];
    wire [15:0] ea = calc_ea(xfer_mode, base, ext_word, step, xfer_word);
    // full word onto the stack, low byte for byte stores
    wire [15:0] store_val = xfer_word ? src_val : {8'h00, src_val[7:0]};
    wire [15:0] imm_val = xfer_word ? ext_word : {8'h00, ext_word[7:0]};
    wire [15:0] direct_val = xfer_mode == TID_MODE_IMM ? imm_val : base;
    wire [15:0] cur_dst = reg_ff[op_reg_ff];
    // full word from the stack, byte loads keep the high half
    wire [15:0] load_val = op_word_ff ? mem_rdata : {cur_dst[15:8], mem_rdata[7:0]};
    wire mem_fin = (state_ff == TID_ST_MEM) && mem_ack;
    wire post_upd = mem_fin && (op_mode_ff == TID_MODE_POSTINC);
    wire load_upd = mem_fin && !op_store_ff;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            TID_ST_IDLE: if (run && !reg_only) nxt_state = TID_ST_MEM;
            TID_ST_MEM: if (mem_ack) nxt_state = TID_ST_IDLE;
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_ff <= TID_ST_IDLE;
            instr_ready <= 1'b0;
            illegal <= 1'b0;
            done <= 1'b0;
            group_out <= TID_GRP_TRANSFER;
        end else begin
            state_ff <= nxt_state;
            instr_ready <= nxt_state == TID_ST_IDLE;
            illegal <= reject;
            done <= (run && reg_only) || mem_fin;
            if (take && code_ok) group_out <= dec_group;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_word <= 1'b0;
            mem_addr <= 16'h0000;
            mem_wdata <= 16'h0000;
        end else if (run && !reg_only) begin
            mem_rd <= !xfer_store;
            mem_wr <= xfer_store;
            mem_word <= xfer_word;
            mem_addr <= ea;
            mem_wdata <= store_val;
        end else if (mem_fin) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            op_store_ff <= 1'b0;
            op_word_ff <= 1'b0;
            op_reg_ff <= 3'h0;
            op_areg_ff <= 3'h0;
            op_mode_ff <= TID_MODE_DIRECT;
            op_step_ff <= 16'h0000;
        end else if (run) begin
            op_store_ff <= xfer_store;
            op_word_ff <= xfer_word;
            op_reg_ff <= xfer_reg;
            op_areg_ff <= addr_reg;
            op_mode_ff <= xfer_mode;
            op_step_ff <= step;
        end
    end

    // a load into its own address register wins over the step
    always_ff @(posedge clock) begin
        if (rst) begin
            for (int i = 0; i < 8; i++) reg_ff[i] <= 16'h0000;
            peek_data <= 16'h0000;
        end else begin
            if (run && reg_only) reg_ff[xfer_reg] <= direct_val;
            if (run && xfer_mode == TID_MODE_PREDEC) reg_ff[addr_reg] <= base - step;
            // step size follows the transfer size
            if (post_upd) reg_ff[op_areg_ff] <= reg_ff[op_areg_ff] + op_step_ff;
            // load result lands in the register
            if (load_upd) reg_ff[op_reg_ff] <= load_val;
            peek_data <= reg_ff[peek_sel];
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    sequence s_push_take;
        run && xfer_store && xfer_word && xfer_mode == TID_MODE_PREDEC
            && addr_reg == `TID_STACK_REG;
    endsequence
    sequence s_word_req;
        mem_rd || mem_wr;
    endsequence

    a_group_range: assert property (take && !code_ok |=> illegal && !done)
        else $error("out of range code not rejected");
    a_push_word: assert property (s_push_take |=> mem_wr && mem_word
            && mem_addr == (($past(base) - 16'h0002) & 16'hFFFE)
            && mem_wdata == $past(src_val))
        else $error("stack store wrong address or data");
    a_predec_keep: assert property (run && xfer_mode == TID_MODE_PREDEC
            |=> reg_ff[$past(addr_reg)] == $past(base) - $past(step))
        else $error("predecrement register not lowered");
    a_postinc_step: assert property (post_upd && op_areg_ff != op_reg_ff | op_store_ff
            |=> reg_ff[$past(op_areg_ff)] == $past(reg_ff[op_areg_ff]) + $past(op_step_ff))
        else $error("postincrement register not raised");
    a_pop_full: assert property (load_upd && op_word_ff
            |=> reg_ff[$past(op_reg_ff)] == $past(mem_rdata))
        else $error("stack load did not move full word");
    a_short_page: assert property (run && xfer_mode == TID_MODE_ABS8
            |=> mem_addr[15:8] == 8'hFF && !mem_word)
        else $error("short absolute page wrong");
    a_word_even: assert property (s_word_req and mem_word |-> !mem_addr[0])
        else $error("odd word address issued");
    a_abs8_word: assert property (take && is_xfer && bad_abs8 |=> illegal && !mem_rd && !mem_wr)
        else $error("word short absolute accepted");
    a_stack_byte: assert property (run && !xfer_word && xfer_mode == TID_MODE_POSTINC
            |=> op_step_ff == 16'h0001 && mem_rd)
        else $error("byte postincrement step wrong");
    a_ack_done: assert property (s_word_req ##0 mem_ack
            |=> done && instr_ready && !mem_rd && !mem_wr)
        else $error("memory access did not finish");
    a_reg_move: assert property (run && reg_only |=> done && instr_ready
            && reg_ff[$past(xfer_reg)] == $past(direct_val))
        else $error("register move missing");
    a_imm_store: assert property (take && is_xfer && bad_imm
            |=> illegal && !mem_rd && !mem_wr)
        else $error("store to immediate accepted");
    a_group_hold: assert property (take && !code_ok |=> $stable(group_out))
        else $error("group changed on rejected code");
endmodule

// >>> tid_mem_model.sv
`timescale 1ns/1ps
module tid_mem_model (
    input wire logic clock,              // cpu clock
    input wire logic rst,                // synchronous reset, active high
    input wire logic mem_rd,             // read request
    input wire logic mem_wr,             // write request
    input wire logic [15:0] mem_addr,    // access address
    input wire logic [15:0] mem_wdata,   // write data
    input wire logic mem_word,           // 1: word access
    input wire logic [3:0] lat,          // wait cycles before ack
    output logic mem_ack,                // one-cycle completion
    output logic [15:0] mem_rdata        // read data, valid with ack only
);
    logic [15:0] mem [logic [15:0]];
    int cnt;
    logic last_word;
    // answers after lat idle cycles; read data is junk outside the ack cycle
    always @(posedge clock) begin
        if (rst) begin
            mem_ack <= 1'b0;
            cnt <= 0;
            last_word <= 1'b0;
            mem_rdata <= 16'hA5A5;
        end else if (mem_ack) begin
            mem_ack <= 1'b0;
            cnt <= 0;
            mem_rdata <= ~mem_rdata;
        end else if ((mem_rd || mem_wr) && cnt >= lat) begin
            mem_ack <= 1'b1;
            if (mem_wr) begin
                mem[mem_addr] = mem_wdata;
                last_word <= mem_word;
            end
            mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : 16'h0000;
        end else begin
            if (mem_rd || mem_wr) cnt <= cnt + 1;
            mem_rdata <= ~mem_rdata;
        end
    end
endmodule

// >>> tb_data_transfer_instruction_decode.sv
`timescale 1ns/1ps
module tb_data_transfer_instruction_decode;
    import tid_pkg::*;
    logic clock = 0, rst = 1, instr_valid = 0, xfer_store = 0, xfer_word = 0, mem_ack;
    logic [5:0] instr_code = 6'h00;
    tid_mode_type xfer_mode = TID_MODE_DIRECT;
    logic [2:0] xfer_reg = 3'h0, addr_reg = 3'h0, peek_sel = 3'h0;
    logic [15:0] ext_word = 16'h0000, mem_rdata, mem_addr, mem_wdata, peek_data;
    logic [3:0] lat = 4'h0;
    logic instr_ready, illegal, done, mem_rd, mem_wr, mem_word;
    tid_group_type group_out;
    int error_cnt = 0, n_tests = 0;
    logic [1:0] r;
    logic [15:0] v;
    tid_transfer_decode i_dut (.clock(clock), .rst(rst), .instr_valid(instr_valid),
        .instr_code(instr_code), .xfer_store(xfer_store), .xfer_word(xfer_word),
        .xfer_mode(xfer_mode), .xfer_reg(xfer_reg), .addr_reg(addr_reg), .ext_word(ext_word),
        .mem_ack(mem_ack), .mem_rdata(mem_rdata), .peek_sel(peek_sel),
        .instr_ready(instr_ready), .group_out(group_out), .illegal(illegal), .done(done),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_word(mem_word), .peek_data(peek_data));
    tid_mem_model i_mem (.clock(clock), .rst(rst), .mem_rd(mem_rd), .mem_wr(mem_wr),
        .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_word(mem_word), .lat(lat),
        .mem_ack(mem_ack),
        .mem_rdata(mem_rdata));
    initial begin
        forever #25 clock = ~clock;
    end
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, n_tests);
        if (error_cnt == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic chk_grp(input tid_group_type got, input tid_group_type exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t group got %0d exp %0d", $time, got, exp);
        end
    endtask
    // result: 1 done, 2 illegal, 0 neither within the bound
    task automatic issue(input logic [5:0] c, input logic st, input logic w,
        input tid_mode_type m, input logic [2:0] xr, input logic [2:0] ar,
        input logic [15:0] ex, output logic [1:0] res);
        int k;
        res = 2'h0;
        // one edge between calls so valid never drops and rises in one time step
        @(posedge clock) #2;
        for (k = 0; k < 50 && instr_ready !== 1'b1; k++) @(posedge clock) #2;
        if (instr_ready !== 1'b1) begin
            error_cnt++;
            $display("[ERR] %0t ready timeout", $time);
            tally_and_finish();
        end
        instr_valid = 1; instr_code = c; xfer_store = st; xfer_word = w;
        xfer_mode = m; xfer_reg = xr; addr_reg = ar; ext_word = ex;
        @(posedge clock) #2;
        instr_valid = 0;
        for (k = 0; k < 12 && res == 2'h0; k++) begin
            if (done === 1'b1) res = 2'h1;
            else if (illegal === 1'b1) res = 2'h2;
            else @(posedge clock) #2;
        end
    endtask
    task automatic peek(input logic [2:0] n, output logic [15:0] val);
        peek_sel = n;
        repeat (2) @(posedge clock) #2;
        val = peek_data;
    endtask
    function automatic tid_group_type exp_grp(input int c);
        if (c == 0) return TID_GRP_TRANSFER;
        if (c <= 14) return TID_GRP_ARITH;
        if (c <= 18) return TID_GRP_LOGIC;
        if (c <= 26) return TID_GRP_SHIFT;
        if (c <= 40) return TID_GRP_BIT;
        if (c <= 45) return TID_GRP_BRANCH;
        if (c <= 53) return TID_GRP_SYSCTL;
        return TID_GRP_BLOCK;
    endfunction
    task automatic t_groups();
        for (int c = 1; c < 64; c++) begin
            issue(c[5:0], 1'b0, 1'b1, TID_MODE_DIRECT, 3'h0, 3'h0, 16'h0000, r);
            chk16({14'h0, r}, (c < 55) ? 16'h0000 : 16'h0002, "group pulse");
            if (c < 55) chk_grp(group_out, exp_grp(c));
            else chk_grp(group_out, TID_GRP_BLOCK);
        end
    endtask
    task automatic t_reg_ops();
        issue(6'h00, 1'b0, 1'b1, TID_MODE_IMM, 3'h1, 3'h0, 16'hBEEF, r);
        issue(6'h00, 1'b0, 1'b0, TID_MODE_IMM, 3'h2, 3'h0, 16'h1234, r);
        peek(3'h2, v); chk16(v, 16'h0034, "byte imm");
        issue(6'h00, 1'b0, 1'b1, TID_MODE_DIRECT, 3'h2, 3'h1, 16'h0000, r);
        peek(3'h2, v); chk16(v, 16'hBEEF, "direct");
    endtask
    task automatic t_stack();
        lat = 4'h3;
        issue(6'h00, 1'b0, 1'b1, TID_MODE_IMM, 3'h7, 3'h0, 16'h0100, r);
        issue(6'h00, 1'b0, 1'b1, TID_MODE_IMM, 3'h3, 3'h0, 16'h1234, r);
        issue(6'h00, 1'b1, 1'b1, TID_MODE_PREDEC, 3'h3, 3'h7, 16'h0000, r);
        chk16({14'h0, r}, 16'h0001, "push done");
        chk16(i_mem.mem[16'h00FE], 16'h1234, "push data");
        chk16({15'h0, i_mem.last_word}, 16'h0001, "push size");
        peek(3'h7, v); chk16(v, 16'h00FE, "push sp");
        lat = 4'h0;
        issue(6'h00, 1'b0, 1'b1, TID_MODE_POSTINC, 3'h4, 3'h7, 16'h0000, r);
        peek(3'h4, v); chk16(v, 16'h1234, "pop data");
        peek(3'h7, v); chk16(v, 16'h0100, "pop sp");
        issue(6'h00, 1'b0, 1'b0, TID_MODE_POSTINC, 3'h4, 3'h7, 16'h0000, r);
        peek(3'h4, v); chk16(v, 16'h1200, "byte pop keeps high");
        peek(3'h7, v); chk16(v, 16'h0101, "byte pop sp");
    endtask
    task automatic t_modes();
        issue(6'h00, 1'b0, 1'b1, TID_MODE_IMM, 3'h5, 3'h0, 16'h0200, r);
        issue(6'h00, 1'b1, 1'b0, TID_MODE_PREDEC, 3'h3, 3'h5, 16'h0000, r);
        chk16(i_mem.mem[16'h01FF], 16'h0034, "byte predec");
        issue(6'h00, 1'b1, 1'b0, TID_MODE_ABS8, 3'h3, 3'h0, 16'h0042, r);
        chk16(i_mem.mem[16'hFF42], 16'h0034, "short abs");
        chk16({15'h0, i_mem.last_word}, 16'h0000, "short abs size");
        issue(6'h00, 1'b1, 1'b1, TID_MODE_ABS8, 3'h3, 3'h0, 16'h0042, r);
        chk16({14'h0, r}, 16'h0002, "word short abs");
        issue(6'h00, 1'b1, 1'b1, TID_MODE_ABS16, 3'h3, 3'h0, 16'h0301, r);
        chk16(i_mem.mem[16'h0300], 16'h1234, "odd word");
        chk16({15'h0, i_mem.last_word}, 16'h0001, "odd word size");
        issue(6'h00, 1'b1, 1'b1, TID_MODE_IMM, 3'h3, 3'h0, 16'h0000, r);
        chk16({14'h0, r}, 16'h0002, "store imm");
        issue(6'h00, 1'b0, 1'b1, TID_MODE_DISP16, 3'h6, 3'h5, 16'h0101, r);
        peek(3'h6, v); chk16(v, 16'h1234, "disp16 load");
        issue(6'h00, 1'b0, 1'b1, TID_MODE_INDIRECT, 3'h1, 3'h5, 16'h0000, r);
        chk16({14'h0, r}, 16'h0001, "indirect");
        peek(3'h1, v); chk16(v, 16'h0000, "indirect load");
    endtask
    task automatic t_reset();
        issue(6'h00, 1'b0, 1'b1, TID_MODE_IMM, 3'h2, 3'h0, 16'h5555, r);
        issue(6'h13, 1'b0, 1'b1, TID_MODE_DIRECT, 3'h0, 3'h0, 16'h0000, r);
        rst = 1;
        repeat (2) @(posedge clock) #2;
        chk16({15'h0, instr_ready}, 16'h0000, "ready in mid reset");
        rst = 0;
        peek(3'h2, v); chk16(v, 16'h0000, "reg after reset");
        chk16({15'h0, instr_ready}, 16'h0001, "ready after reset");
        chk_grp(group_out, TID_GRP_TRANSFER);
    endtask
    initial begin
        repeat (8) @(posedge clock) #2;
        chk16({15'h0, instr_ready}, 16'h0000, "ready in reset");
        rst = 0;
        chk_grp(group_out, TID_GRP_TRANSFER);
        t_groups();
        t_reg_ops();
        t_stack();
        t_modes();
        t_reset();
        tally_and_finish();
    end
endmodule
